// ===== core/mpr_regs.sv
// Memory partition registers behind a classic Wishbone slave
// How it works
// (R01) Fixed read-only word gives data RAM bytes
// (R02) Software writes user flash base bits 19..11
// (R03) Bits 10..0 read zero, writes ignored
// (R04) Bits 31..20 always read zero
// (R05) Reset clears the user flash base
// (R06) Software keeps base within program flash size
// (R07) Writes to the RAM size word do nothing
`timescale 1ns/10ps
module mpr_regs #(
  parameter logic [31:0] DATA_RAM_BYTES = mpr_pkg::DRAM_SIZE_16K
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [31:0] user_flash_base_o
);
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  mpr_field_if fld ();

  // Address decode on the word index only; byte bits are don't care
  wire req = wb_cyc_i && wb_stb_i;
  wire [5:0] word = wb_adr_i[7:mpr_pkg::WORD_LSB];
  wire hit_ram =
    (word == mpr_pkg::OFS_DATA_RAM_SIZE[7:mpr_pkg::WORD_LSB]);
  wire hit_ufb =
    (word == mpr_pkg::OFS_USER_FLASH_BASE[7:mpr_pkg::WORD_LSB]);
  wire take = req && !ack_ff;

  // Read selection; the RAM size word is a constant, so no store exists
  wire [31:0] rd_data = hit_ram ? DATA_RAM_BYTES : // R01 R07
    hit_ufb ? (fld.value & mpr_pkg::UFB_MASK) : // R03 R04
    mpr_pkg::READ_ZERO;

  // Writes commit on the edge where the master samples ack
  assign fld.wr_en = req && wb_we_i && ack_ff && hit_ufb; // R02 R07
  assign fld.wdata = wb_dat_i;
  assign fld.sel = wb_sel_i;

  // Answer one cycle after the request; ack drops the cycle after
  assign nxt_ack = take;
  assign nxt_dat = take ? rd_data : dat_ff;

  // Bus answer registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_ff <= 1'b0;
      dat_ff <= mpr_pkg::READ_ZERO;
    end
    else
    begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  // Writable field; no bound check, software keeps it legal
  mpr_field_reg #(
    .LSB(mpr_pkg::UFB_LSB),
    .MSB(mpr_pkg::UFB_MSB),
    .RESET(mpr_pkg::UFB_RESET)
  ) u_ufb (
    .clk(clk),
    .nrst(nrst),
    .fld(fld.field)
  );

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign user_flash_base_o = fld.value; // R05

  // Size parameter must be one of the three legal readings
  ram_size_legal_a: assert property ( // R01
    @(posedge clk) disable iff (!nrst)
    DATA_RAM_BYTES == mpr_pkg::DRAM_SIZE_16K ||
    DATA_RAM_BYTES == mpr_pkg::DRAM_SIZE_32K ||
    DATA_RAM_BYTES == mpr_pkg::DRAM_SIZE_64K)
    else $error("data RAM size reading is not legal");

  // Reading the RAM size word returns the fixed value, writes or not
  ram_size_read_a: assert property ( // R07
    @(posedge clk) disable iff (!nrst)
    req && !ack_ff && !wb_we_i && hit_ram |=>
    wb_ack_o && wb_dat_o == DATA_RAM_BYTES)
    else $error("RAM size word read back wrong");

  // A full-lane write lands in bits 19..11 after the ack edge
  ufb_write_a: assert property ( // R02
    @(posedge clk) disable iff (!nrst)
    fld.wr_en && wb_sel_i[1] && wb_sel_i[2] |=>
    user_flash_base_o[19:11] == $past(wb_dat_i[19:11]))
    else $error("user flash base write lost");

  // Base stays on 2 KB steps on the output port
  ufb_low_zero_a: assert property ( // R03
    @(posedge clk) disable iff (!nrst)
    user_flash_base_o[10:0] == 11'h000)
    else $error("user flash base low bits not zero");

  // Reads of the base word also show zero low bits
  ufb_read_low_a: assert property ( // R03
    @(posedge clk) disable iff (!nrst)
    wb_ack_o && $past(hit_ufb) && !$past(wb_we_i) |->
    wb_dat_o[10:0] == 11'h000)
    else $error("user flash base read low bits not zero");

  // Unimplemented top bits never show up
  ufb_high_zero_a: assert property ( // R04
    @(posedge clk) disable iff (!nrst)
    user_flash_base_o[31:20] == 12'h000)
    else $error("user flash base top bits not zero");

  // First cycle out of reset shows a cleared base
  ufb_reset_a: assert property ( // R05
    @(posedge clk) disable iff (!nrst)
    !$past(nrst) |-> user_flash_base_o == mpr_pkg::UFB_RESET)
    else $error("user flash base not cleared by reset");

  // Base only moves on a decoded write
  ufb_hold_a: assert property ( // R02
    @(posedge clk) disable iff (!nrst)
    !fld.wr_en |=> $stable(user_flash_base_o))
    else $error("user flash base changed without a write");

  // One-cycle answer, then ack falls
  bus_ack_a: assert property (
    @(posedge clk) disable iff (!nrst)
    take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer timing wrong");
endmodule

// ===== core/mpr_pkg.sv
// Constants shared by the memory partition register block
package mpr_pkg;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned LANE_W = 8;
  // Byte offsets of the two registers
  localparam logic [7:0] OFS_DATA_RAM_SIZE = 8'h00;
  localparam logic [7:0] OFS_USER_FLASH_BASE = 8'h04;
  // Word index lives above the byte lane bits
  localparam int unsigned WORD_LSB = 2;
  // Legal data RAM size readings, in bytes
  localparam logic [31:0] DRAM_SIZE_16K = 32'h0000_4000;
  localparam logic [31:0] DRAM_SIZE_32K = 32'h0000_8000;
  localparam logic [31:0] DRAM_SIZE_64K = 32'h0001_0000;
  // Writable window of the user flash base register
  localparam int unsigned UFB_LSB = 11;
  localparam int unsigned UFB_MSB = 19;
  localparam logic [31:0] UFB_RESET = 32'h0000_0000;
  localparam logic [31:0] UFB_MASK = 32'h000F_F800;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

// ===== core/mpr_field_if.sv
// Carrier between the bus decoder and the writable field register
`timescale 1ns/10ps
interface mpr_field_if;
  logic wr_en;
  logic [31:0] wdata;
  logic [3:0] sel;
  logic [31:0] value;
  modport ctrl (output wr_en, output wdata, output sel, input value);
  modport field (input wr_en, input wdata, input sel, output value);
endinterface

// ===== core/mpr_field_reg.sv
// Register whose bits LSB..MSB are writable by byte lane, others read zero
`timescale 1ns/10ps
module mpr_field_reg #(
  parameter int unsigned LSB = mpr_pkg::UFB_LSB,
  parameter int unsigned MSB = mpr_pkg::UFB_MSB,
  parameter logic [31:0] RESET = mpr_pkg::UFB_RESET
)(
  input wire logic clk,
  input wire logic nrst,
  mpr_field_if.field fld
);
  logic [31:0] value_ff;
  logic [31:0] nxt_value;
  wire [31:0] wmask;

  // Per-bit write enable: inside the field and its own byte lane
  genvar i;
  generate
    for (i = 0; i < 32; i++)
    begin : g_bit
      if (i >= LSB && i <= MSB)
      begin : g_rw
        assign wmask[i] = fld.wr_en && fld.sel[i / mpr_pkg::LANE_W]; // R02
      end
      else
      begin : g_ro
        // Never enabled, so writes cannot disturb it
        assign wmask[i] = 1'b0; // R03 R04
      end
    end
  endgenerate

  // Merge new lanes over old; one store avoids split drivers per bit
  assign nxt_value = (value_ff & ~wmask) | (fld.wdata & wmask);

  // Field store
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      value_ff <= RESET; // R05
    else
      value_ff <= nxt_value;
  end

  assign fld.value = value_ff;
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the memory partition registers
`timescale 1ns/10ps
module testbench;
  logic clk, nrst, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, ufb, mdl;
  logic [31:0] exp_q[$];
  int num_errors, compares, cycles;
  mpr_regs #(.DATA_RAM_BYTES(mpr_pkg::DRAM_SIZE_32K)) dut_u (.clk(clk),
    .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .user_flash_base_o(ufb));
  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic cmp(string what, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One classic cycle; a read leaves its expected word for the monitor
  task automatic bus(logic w, logic [7:0] a, logic [3:0] s,
    logic [31:0] d, logic [31:0] e);
    int n;
    if (!w)
      exp_q.push_back(e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
      cmp("ack_wait", 32'h0000_0001, 32'h0000_0000);
    cyc <= 1'b0;
    stb <= 1'b0;
    // Reference model: only the lanes given by sel, then the writable mask
    if (w && a == mpr_pkg::OFS_USER_FLASH_BASE)
    begin
      for (int i = 0; i < 4; i++)
        if (s[i])
          mdl[8*i +: 8] = d[8*i +: 8];
      mdl = mdl & mpr_pkg::UFB_MASK;
    end
    @(posedge clk);
    cmp("ack_drop", 32'h0000_0000, {31'h0, ack});
    cmp("ufb_out", mdl, ufb);
  endtask
  // Monitor: every read answer takes the oldest note off the queue
  always @(posedge clk)
    if (ack === 1'b1 && we === 1'b0)
      cmp("rdata", exp_q.size() ? exp_q.pop_front() : 32'hDEAD_BEEF, rdat);
  // Hang guard, well above the roughly 130 cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  initial
  begin
    nrst = 1'b0;
    {cyc, stb, we, adr, sel, wdat, mdl} = '0;
    void'($urandom(86960));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    cmp("ufb_rst", 32'h0000_0000, ufb);
    bus(0, 8'h04, 4'hF, 0, 32'h0000_0000);
    bus(0, 8'h00, 4'hF, 0, mpr_pkg::DRAM_SIZE_32K);
    bus(1, 8'h00, 4'hF, $urandom, 0);
    bus(0, 8'h00, 4'hF, 0, mpr_pkg::DRAM_SIZE_32K);
    $display("fixed size word test done");
    for (int i = 0; i < 16; i++)
    begin
      bus(1, 8'h04, i[3:0], $urandom, 0);
      bus(0, 8'h04, 4'hF, 0, mdl);
    end
    $display("base field lane test done");
    bus(1, 8'h08, 4'hF, $urandom, 0);
    bus(0, 8'h08, 4'hF, 0, 32'h0000_0000);
    bus(0, 8'h04, 4'hF, 0, mdl);
    bus(1, 8'h04, 4'hF, 32'hFFFF_FFFF, 0);
    nrst <= 1'b0;
    @(posedge clk);
    cmp("ufb_midrst", 32'h0000_0000, ufb);
    mdl = 32'h0000_0000;
    nrst <= 1'b1;
    @(posedge clk);
    bus(0, 8'h04, 4'hF, 0, 32'h0000_0000);
    $display("unmapped and reset test done");
    end_of_test();
  end
endmodule
